// file: hdl/fgdeil_pkg.sv
// constants shared by the dual-edge pin logic: register map, control fields, modes
package fgdeil_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  // control field positions
  localparam int POS_MODE = 0;
  localparam int POS_IN_REG = 2;
  localparam int POS_IN_NEG = 3;
  localparam int POS_OUT_REG = 4;
  localparam int POS_OUT_NEG = 5;
  localparam int POS_OE_REG = 6;
  localparam int POS_OE_NEG = 7;
  localparam int POS_INVERT = 8;
  localparam int POS_DUAL = 9;
  localparam int POS_RESYNC = 10;
  localparam int POS_ROUTE = 12;
  localparam int CTRL_W = 16;
  // writable control bits; bit 11 is reserved and reads zero
  localparam logic [15:0] CTRL_MASK = 16'hf7ff;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // status field positions
  localparam int POS_ST_PAD = 0;
  localparam int POS_ST_CORE_IN = 1;
  localparam int POS_ST_OE = 3;
  localparam int POS_ST_DUAL_OK = 4;
  // pin modes
  localparam logic [1:0] MODE_INPUT = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h1;
  localparam logic [1:0] MODE_BIDIR = 2'h2;
  localparam logic [1:0] MODE_CLKOUT = 2'h3;
  // synchroniser lanes
  localparam int SYN_PAD = 0;
  localparam int SYN_CAP = 1;
  localparam int SYN_LAUNCH = 2;
  localparam int SYN_CLKNET = 3;
  localparam int SYN_W = 4;
endpackage

// file: hdl/fgdeil_gpio.sv
// one general-purpose pin cell with registered, dual-edge and bypass paths
//
// Overview of operation
// - input mode: only pad-to-core path active, driver off; registered or direct.
// - registered input samples on capture clock, rising or falling edge as set.
// - bypass input skips the input register; only the core_clk state register holds it.
// - dual-edge input: one sample on capture rise, one on capture fall.
// - output mode: only core-to-pad path active; registered or direct.
// - registered output updates on launch clock, rising or falling edge as set.
// - output and bidirectional modes may invert the driven value.
// - dual-edge output: two launch registers multiplexed onto the pad.
// - bidirectional: input, output and enable paths all active, each optionally registered.
// - bidirectional: capture clock for input, launch clock for output and enable.
// - input and output registration are chosen independently.
// - clock-output mode drives the core clock net onto the pad.
// - core input bit 0 normal or rise sample, bit 1 fall sample.
// - bypass input routes to clock, control and reference-clock resources.
// - dual-edge mode exchanges two bits per pin with the core.
// - normal dual-edge hand-off moves each bit on its own edge.
// - resync dual-edge hand-off moves both bits on rising edge only.
// - resync input delays the fall sample half a period to align it.
// - differential-pair pins used single-ended have no dual-edge capability.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module fgdeil_gpio #(
  parameter int ADDR_W = 12,
  parameter bit DIFF_PAIR = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core fabric side
  input wire logic [1:0] core_out,
  input wire logic core_oe,
  input wire logic capture_clock,
  input wire logic launch_clock,
  input wire logic clock_net_in,
  output logic [1:0] core_in,
  // alternate function routes
  output logic bypass_input,
  output logic global_clock_net,
  output logic global_control_net,
  output logic synth_reference_input,
  output logic camera_phy_reference_input,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] f;
    logic [15:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] core_in;
    logic fall_hold;
    logic rise_drive;
    logic fall_drive;
    logic out_q;
    logic oe_q;
    logic pad_out;
    logic pad_oe;
    logic bypass;
    logic [3:0] route;
  } fgdeil_state_t;

  fgdeil_state_t s;
  fgdeil_state_t next_s;

  logic [1:0] mode;
  logic in_en;
  logic out_en;
  logic dual;
  logic resync;
  logic cap_rise;
  logic cap_fall;
  logic lau_rise;
  logic lau_fall;
  logic rd_hit;
  logic [31:0] status;
  logic [3:0] f_next;

  // decoded configuration; dual-edge is masked off for differential-pair pins
  assign mode = s.ctrl[fgdeil_pkg::POS_MODE +: 2];
  assign in_en = (mode == fgdeil_pkg::MODE_INPUT) || (mode == fgdeil_pkg::MODE_BIDIR);
  assign out_en = (mode == fgdeil_pkg::MODE_OUTPUT) || (mode == fgdeil_pkg::MODE_BIDIR);
  assign dual = s.ctrl[fgdeil_pkg::POS_DUAL] && !DIFF_PAIR;
  assign resync = s.ctrl[fgdeil_pkg::POS_RESYNC];

  // agree filter kept apart so the edge flags do not loop back into the main process
  always_comb begin
    f_next = s.f;
    for (int i = 0; i < fgdeil_pkg::SYN_W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        f_next[i] = s.s3[i];
      end
    end
  end

  // edges of the filtered clock lanes, seen in the same cycle the filter accepts the new level
  assign cap_rise = !s.f[fgdeil_pkg::SYN_CAP] && f_next[fgdeil_pkg::SYN_CAP];
  assign cap_fall = s.f[fgdeil_pkg::SYN_CAP] && !f_next[fgdeil_pkg::SYN_CAP];
  assign lau_rise = !s.f[fgdeil_pkg::SYN_LAUNCH] && f_next[fgdeil_pkg::SYN_LAUNCH];
  assign lau_fall = s.f[fgdeil_pkg::SYN_LAUNCH] && !f_next[fgdeil_pkg::SYN_LAUNCH];

  // status word shows live pin state
  always_comb begin
    status = 32'h0000_0000;
    status[fgdeil_pkg::POS_ST_PAD] = s.f[fgdeil_pkg::SYN_PAD];
    status[fgdeil_pkg::POS_ST_CORE_IN +: 2] = s.core_in;
    status[fgdeil_pkg::POS_ST_OE] = s.pad_oe;
    status[fgdeil_pkg::POS_ST_DUAL_OK] = !DIFF_PAIR;
  end

  assign rd_hit = (paddr == ADDR_W'(fgdeil_pkg::ADDR_CTRL))
    || (paddr == ADDR_W'(fgdeil_pkg::ADDR_STATUS));

  // next-state logic for the whole cell
  always_comb begin
    logic act_cap;
    logic act_lau;
    logic act_oe;
    logic val;
    logic oe_val;
    logic eff_oe;
    logic pad_now;
    act_cap = 1'b0;
    act_lau = 1'b0;
    act_oe = 1'b0;
    val = 1'b0;
    oe_val = 1'b0;
    eff_oe = 1'b0;
    pad_now = 1'b0;
    next_s = s;

    // three-stage synchronisers; a level is accepted once stages two and three agree
    next_s.s1 = {clock_net_in, launch_clock, capture_clock, pad_in};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.f = f_next;
    pad_now = next_s.f[fgdeil_pkg::SYN_PAD];

    // apb: pready rises in the second access cycle, write lands on the edge that ends it
    next_s.pready = psel && penable && !s.pready;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.pslverr = !rd_hit;
      next_s.prdata = 32'h0000_0000;
      if (!pwrite && paddr == ADDR_W'(fgdeil_pkg::ADDR_CTRL)) begin
        next_s.prdata = {16'h0000, s.ctrl};
      end else if (!pwrite && paddr == ADDR_W'(fgdeil_pkg::ADDR_STATUS)) begin
        next_s.prdata = status;
      end
    end
    if (psel && penable && s.pready && pwrite && paddr == ADDR_W'(fgdeil_pkg::ADDR_CTRL)) begin
      next_s.ctrl = pwdata[15:0] & fgdeil_pkg::CTRL_MASK;
    end

    // input path: each capture edge choice independent of the output side
    act_cap = s.ctrl[fgdeil_pkg::POS_IN_NEG] ? cap_fall : cap_rise;
    if (!in_en) begin
      next_s.core_in = 2'h0;
    end else if (dual) begin
      if (resync) begin
        // fall sample waits half a period so both bits leave on the rise
        if (cap_fall) begin
          next_s.fall_hold = pad_now;
        end
        if (cap_rise) begin
          next_s.core_in = {s.fall_hold, pad_now};
        end
      end else begin
        if (cap_rise) begin
          next_s.core_in[0] = pad_now;
        end
        if (cap_fall) begin
          next_s.core_in[1] = pad_now;
        end
      end
    end else if (s.ctrl[fgdeil_pkg::POS_IN_REG]) begin
      if (act_cap) begin
        next_s.core_in = {1'b0, pad_now};
      end
    end else begin
      next_s.core_in = {1'b0, pad_now};
    end

    // bypass skips every input register and feeds the chosen resources
    next_s.bypass = in_en && pad_now;
    next_s.route = {4{in_en && pad_now}} & s.ctrl[fgdeil_pkg::POS_ROUTE +: 4];

    // output path, core bits taken as the core presents them
    act_lau = s.ctrl[fgdeil_pkg::POS_OUT_NEG] ? lau_fall : lau_rise;
    if (dual) begin
      if (resync) begin
        if (lau_rise) begin
          next_s.rise_drive = core_out[0];
          next_s.fall_drive = core_out[1];
        end
      end else begin
        if (lau_rise) begin
          next_s.rise_drive = core_out[0];
        end
        if (lau_fall) begin
          next_s.fall_drive = core_out[1];
        end
      end
      // launch clock level picks which register faces the pad
      val = next_s.f[fgdeil_pkg::SYN_LAUNCH] ? next_s.rise_drive : next_s.fall_drive;
    end else if (s.ctrl[fgdeil_pkg::POS_OUT_REG]) begin
      if (act_lau) begin
        next_s.out_q = core_out[0];
      end
      val = next_s.out_q;
    end else begin
      val = core_out[0];
    end
    val = val ^ (out_en && s.ctrl[fgdeil_pkg::POS_INVERT]);

    // enable path shares the launch clock with the output register
    act_oe = s.ctrl[fgdeil_pkg::POS_OE_NEG] ? lau_fall : lau_rise;
    if (act_oe) begin
      next_s.oe_q = core_oe;
    end
    oe_val = s.ctrl[fgdeil_pkg::POS_OE_REG] ? next_s.oe_q : core_oe;

    unique case (mode)
      fgdeil_pkg::MODE_INPUT: eff_oe = 1'b0;
      fgdeil_pkg::MODE_OUTPUT: eff_oe = 1'b1;
      fgdeil_pkg::MODE_BIDIR: eff_oe = oe_val;
      fgdeil_pkg::MODE_CLKOUT: begin
        eff_oe = 1'b1;
        val = next_s.f[fgdeil_pkg::SYN_CLKNET];
      end
    endcase
    // undriven pad also parks the data line low
    next_s.pad_oe = eff_oe;
    next_s.pad_out = eff_oe && val;
  end

  // single state register; every output leaves from here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign core_in = s.core_in;
  assign bypass_input = s.bypass;
  assign global_clock_net = s.route[0];
  assign global_control_net = s.route[1];
  assign synth_reference_input = s.route[2];
  assign camera_phy_reference_input = s.route[3];
  assign pad_out = s.pad_out;
  assign pad_oe = s.pad_oe;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // steps of a resync input transfer
  sequence q_fall_caught;
    in_en && dual && resync && cap_fall;
  endsequence
  sequence q_rise_hand;
    in_en && dual && resync && cap_rise;
  endsequence

  property p_input_undriven;
    (mode == fgdeil_pkg::MODE_INPUT) |=> !pad_oe;
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("pad driven in input mode");

  property p_reg_capture;
    (in_en && !dual && s.ctrl[fgdeil_pkg::POS_IN_REG] && !s.ctrl[fgdeil_pkg::POS_IN_NEG]
      && cap_rise) |=> (core_in[0] == $past(next_s.f[0]));
  endproperty
  a_reg_capture: assert property (p_reg_capture)
    else $error("registered input missed capture edge");

  property p_bypass;
    in_en |=> (bypass_input == $past(next_s.f[0]));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass input not following pad");

  // the fall sample and the rise sample leave together on the capture rise
  property p_resync_align;
    q_rise_hand |=> (core_in == {$past(s.fall_hold), $past(next_s.f[0])});
  endproperty
  a_resync_align: assert property (p_resync_align)
    else $error("resync fall sample not aligned");

  // a caught fall sample is parked, the core side must not move yet
  property p_resync_hold;
    q_fall_caught |=> (s.fall_hold == $past(next_s.f[0])) && $stable(core_in);
  endproperty
  a_resync_hold: assert property (p_resync_hold)
    else $error("resync fall sample reached core early");

  property p_direct_out;
    (mode == fgdeil_pkg::MODE_OUTPUT && !dual && !s.ctrl[fgdeil_pkg::POS_OUT_REG]
      && !s.ctrl[fgdeil_pkg::POS_INVERT]) |=> (pad_out == $past(core_out[0]) && pad_oe);
  endproperty
  a_direct_out: assert property (p_direct_out)
    else $error("direct output not passed to pad");

  property p_invert;
    (mode == fgdeil_pkg::MODE_OUTPUT && !dual && !s.ctrl[fgdeil_pkg::POS_OUT_REG]
      && s.ctrl[fgdeil_pkg::POS_INVERT]) |=> (pad_out == !$past(core_out[0]));
  endproperty
  a_invert: assert property (p_invert)
    else $error("output not inverted");

  property p_dual_mux;
    (out_en && dual) |=> (pad_out == ((s.f[2] ? s.rise_drive : s.fall_drive)
      ^ $past(s.ctrl[fgdeil_pkg::POS_INVERT])) || !pad_oe);
  endproperty
  a_dual_mux: assert property (p_dual_mux)
    else $error("dual-edge output mux wrong");

  property p_clkout;
    (mode == fgdeil_pkg::MODE_CLKOUT) |=> (pad_oe && pad_out == $past(next_s.f[3]));
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock net not on pad");

  property p_undriven_low;
    !pad_oe |-> !pad_out;
  endproperty
  a_undriven_low: assert property (p_undriven_low)
    else $error("pad data active while undriven");

  property p_no_dual_diff;
    DIFF_PAIR |-> !dual;
  endproperty
  a_no_dual_diff: assert property (p_no_dual_diff)
    else $error("dual-edge active on differential-pair pin");

endmodule

// file: test/fgdeil_board.sv
// board-side model of whatever else drives the shared pad
`timescale 1ns/10ps
module fgdeil_board (
  // clock
  input wire logic core_clk,
  // far driver on the board
  input wire logic drive_en,
  input wire logic drive_val,
  // pad from the cell
  input wire logic pad_out,
  input wire logic pad_oe,
  output logic pad_in
);
  logic flt = 1'b0;
  // an undriven pad keeps wandering so a stale value cannot pass for data
  always @(posedge core_clk) begin
    flt <= ~flt;
  end
  // cell drives only with its enable up, otherwise the board may
  assign pad_in = pad_oe ? pad_out : (drive_en ? drive_val : flt);
endmodule

// file: test/fpga_gpio_dual_edge_io_logic_tb.sv
// self-checking bench for the dual-edge pin cell
`timescale 1ns/10ps
module fpga_gpio_dual_edge_io_logic_tb;
  localparam logic [15:0] IREG = 16'h0001 << fgdeil_pkg::POS_IN_REG;
  localparam logic [15:0] INEG = 16'h0001 << fgdeil_pkg::POS_IN_NEG;
  localparam logic [15:0] OREG = 16'h0001 << fgdeil_pkg::POS_OUT_REG;
  localparam logic [15:0] ONEG = 16'h0001 << fgdeil_pkg::POS_OUT_NEG;
  localparam logic [15:0] EREG = 16'h0001 << fgdeil_pkg::POS_OE_REG;
  localparam logic [15:0] INV = 16'h0001 << fgdeil_pkg::POS_INVERT;
  localparam logic [15:0] DUAL = 16'h0001 << fgdeil_pkg::POS_DUAL;
  localparam logic [15:0] RSY = 16'h0001 << fgdeil_pkg::POS_RESYNC;
  // status with pad high, core bit 0 high, pad released, dual allowed
  localparam logic [31:0] ST_IN = (32'h1 << fgdeil_pkg::POS_ST_PAD)
    | (32'h1 << fgdeil_pkg::POS_ST_CORE_IN) | (32'h1 << fgdeil_pkg::POS_ST_DUAL_OK);
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] core_out = 2'h0, core_in;
  logic core_oe = 1'b0, capture_clock = 1'b0, launch_clock = 1'b0, clock_net_in = 1'b0;
  logic ext_en = 1'b1, ext_val = 1'b0, er, pad_in, pad_out, pad_oe, bypass_input;
  logic global_clock_net, global_control_net, synth_reference_input, camera_phy_reference_input;
  int n_mismatch = 0;
  int num_checks = 0;

  // 125 MHz system clock
  always #4 core_clk = ~core_clk;

  fgdeil_gpio #(.ADDR_W(12), .DIFF_PAIR(1'b0)) fgdeil_gpio_inst (.core_clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_out, .core_oe,
    .capture_clock, .launch_clock, .clock_net_in, .core_in, .bypass_input, .global_clock_net,
    .global_control_net, .synth_reference_input, .camera_phy_reference_input, .pad_in,
    .pad_out, .pad_oe);
  fgdeil_board fgdeil_board_inst (.core_clk, .drive_en(ext_en), .drive_val(ext_val),
    .pad_out, .pad_oe, .pad_in);

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready wait", 32'h0, 32'h1);
  endtask
  task automatic wc(input logic [15:0] v);
    apb(1'b1, fgdeil_pkg::ADDR_CTRL, {16'h0000, v});
    wt(8);
  endtask
  // slow pin-side stimulus; sampled clocks need several core cycles to settle
  task automatic drv(input int w, input logic v);
    @(posedge core_clk);
    case (w)
      0: capture_clock <= v;
      1: launch_clock <= v;
      2: clock_net_in <= v;
      3: ext_val <= v;
      4: core_oe <= v;
      5: core_out[0] <= v;
      6: core_out[1] <= v;
      default: ext_en <= v;
    endcase
    wt(8);
  endtask

  task automatic t_regs();
    apb(1'b0, fgdeil_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, {16'h0000, fgdeil_pkg::CTRL_RESET});
    wc(16'hffff);
    apb(1'b0, fgdeil_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl mask", rd, {16'h0000, fgdeil_pkg::CTRL_MASK});
    apb(1'b0, fgdeil_pkg::ADDR_STATUS, 32'h0);
    chk("dual allowed", rd[fgdeil_pkg::POS_ST_DUAL_OK], 1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
  endtask
  task automatic t_input();
    wc(16'ha000 | fgdeil_pkg::MODE_INPUT);
    drv(3, 1'b1);
    chk("in direct", core_in, 2'b01);
    chk("in oe", pad_oe, 0);
    chk("bypass", bypass_input, 1);
    chk("routes", {global_clock_net, global_control_net, synth_reference_input,
      camera_phy_reference_input}, 4'h5);
    apb(1'b0, fgdeil_pkg::ADDR_STATUS, 32'h0);
    chk("status live", rd, ST_IN);
    // no capture edge yet: the register keeps its value while the pad moves
    wc(IREG);
    drv(3, 1'b0);
    chk("in reg hold", core_in, 2'b01);
    chk("bypass unreg", bypass_input, 0);
    drv(0, 1'b1);
    chk("in reg rise", core_in, 2'b00);
    wc(IREG | INEG);
    drv(3, 1'b1);
    drv(0, 1'b0);
    chk("in reg fall", core_in, 2'b01);
    drv(3, 1'b0);
    drv(0, 1'b1);
    chk("in neg no rise", core_in, 2'b01);
  endtask
  task automatic t_dual_in();
    wc(IREG | DUAL);
    drv(3, 1'b1);
    drv(0, 1'b0);
    drv(3, 1'b0);
    drv(0, 1'b1);
    chk("dual in", core_in, 2'b10);
    drv(0, 1'b0);
    chk("dual fall own edge", core_in, 2'b00);
    wc(IREG | DUAL | RSY);
    drv(3, 1'b1);
    drv(0, 1'b1);
    chk("resync rise", core_in, 2'b01);
    drv(0, 1'b0);
    chk("resync fall held", core_in, 2'b01);
    drv(3, 1'b0);
    drv(0, 1'b1);
    chk("resync aligned", core_in, 2'b10);
  endtask
  task automatic t_out();
    drv(4, 1'b1);
    wc(fgdeil_pkg::MODE_OUTPUT);
    drv(5, 1'b1);
    chk("out direct", {pad_oe, pad_out, core_in}, 4'hc);
    wc(fgdeil_pkg::MODE_OUTPUT | INV);
    chk("out invert", pad_out, 0);
    wc(fgdeil_pkg::MODE_OUTPUT | OREG);
    drv(1, 1'b1);
    drv(5, 1'b0);
    chk("out reg hold", pad_out, 1);
    drv(1, 1'b0);
    drv(1, 1'b1);
    chk("out reg rise", pad_out, 0);
    wc(fgdeil_pkg::MODE_OUTPUT | OREG | ONEG);
    drv(5, 1'b1);
    drv(1, 1'b0);
    chk("out reg fall", pad_out, 1);
  endtask
  task automatic t_dual_out();
    wc(fgdeil_pkg::MODE_OUTPUT | OREG | DUAL);
    drv(6, 1'b0);
    drv(1, 1'b1);
    chk("dual out rise", pad_out, 1);
    drv(1, 1'b0);
    chk("dual out fall", pad_out, 0);
    wc(fgdeil_pkg::MODE_OUTPUT | OREG | DUAL | RSY);
    drv(5, 1'b0);
    drv(6, 1'b1);
    drv(1, 1'b1);
    chk("resync out rise", pad_out, 0);
    drv(6, 1'b0);
    drv(1, 1'b0);
    chk("resync out fall", pad_out, 1);
  endtask
  task automatic t_bidir();
    wc(fgdeil_pkg::MODE_BIDIR | EREG);
    drv(4, 1'b0);
    drv(1, 1'b1);
    chk("bidir released", {pad_oe, pad_out}, 2'b00);
    drv(3, 1'b1);
    chk("bidir input", core_in[0], 1);
    drv(7, 1'b0);
    drv(4, 1'b1);
    chk("oe reg hold", pad_oe, 0);
    drv(1, 1'b0);
    drv(1, 1'b1);
    chk("oe reg rise", pad_oe, 1);
    drv(5, 1'b1);
    chk("bidir loop", {pad_out, core_in[0]}, 2'b11);
  endtask
  task automatic t_clk();
    wc(fgdeil_pkg::MODE_CLKOUT);
    drv(2, 1'b1);
    chk("clkout high", {pad_oe, pad_out}, 2'b11);
    drv(2, 1'b0);
    chk("clkout low", {pad_oe, pad_out}, 2'b10);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_input();
    t_dual_in();
    t_out();
    t_dual_out();
    t_bidir();
    t_clk();
    print_verdict();
  end
  // watchdog, well beyond the roughly 600 cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
